// [inc/nsc_pkg.sv]
// Types shared by the host port controller and its timer.
// Assumes nothing beyond a SystemVerilog compiler.
package nsc_pkg;
  // Controller sequence states.
  typedef enum logic [2:0] {
    NSC_POWERUP = 3'b000,
    NSC_IDLE = 3'b001,
    NSC_READ = 3'b010,
    NSC_WR_SEL = 3'b011,
    NSC_WR_STRB = 3'b100,
    NSC_TURN = 3'b101,
    NSC_PRECHG = 3'b110
  } nsc_state_t;
  // Cycle count width, wide enough for the power-up wait.
  typedef logic [22:0] nsc_count_t;
endpackage

// [inc/nsc_regs.svh]
// Timing constants for the nonvolatile SRAM host port controller.
// Assumes a 250 MHz system clock; all counts are in clk_i cycles.
`ifndef NSC_REGS_SVH
`define NSC_REGS_SVH

// Clock period in picoseconds.
`define NSC_CLK_PS 4000
// Least select low time, ns.
`define NSC_SELECT_ACTIVE_MIN_NS 70
// Longest select access time, ns.
`define NSC_SELECT_ACCESS_MAX_NS 70
// Longest gate access time, ns.
`define NSC_GATE_ACCESS_MAX_NS 12
// Longest release time after gate or select high, ns.
`define NSC_RELEASE_MAX_NS 15
// Least time from select low to strobe rise, ns.
`define NSC_SELECT_TO_STROBE_RISE_MIN_NS 70
// Least time before the device drives again after strobe rise, ns.
`define NSC_STROBE_TO_DRIVE_MIN_NS 10
// Least cycle time, ns.
`define NSC_READ_CYCLE_MIN_NS 130
// Least pre-charge time, ns.
`define NSC_PRECHARGE_MIN_NS 60
// Least power-up wait, ms.
`define NSC_POWERUP_WAIT_MIN_MS 10
// Data setup before strobe rise, ns.
`define NSC_DATA_SETUP_MIN_NS 30

// Least times round up to whole cycles; only the read count adds two for the pin synchronizer.
`define NSC_CEIL(ns) (((ns) * 1000 + `NSC_CLK_PS - 1) / `NSC_CLK_PS)
`define NSC_SEL_CYC (`NSC_CEIL(`NSC_SELECT_ACTIVE_MIN_NS))
`define NSC_RD_CYC (`NSC_CEIL(`NSC_SELECT_ACCESS_MAX_NS + 4) + 2)
`define NSC_WR_CYC (`NSC_CEIL(`NSC_SELECT_TO_STROBE_RISE_MIN_NS))
`define NSC_STRB_CYC (`NSC_CEIL(`NSC_DATA_SETUP_MIN_NS))
`define NSC_PC_CYC (`NSC_CEIL(`NSC_PRECHARGE_MIN_NS))
`define NSC_CYC_CYC (`NSC_CEIL(`NSC_READ_CYCLE_MIN_NS))
`define NSC_TA_CYC (`NSC_CEIL(`NSC_RELEASE_MAX_NS))
// Split so the product stays inside 32-bit integer arithmetic.
`define NSC_PU_CYC ((`NSC_POWERUP_WAIT_MIN_MS * 1000000) / (`NSC_CLK_PS / 1000))

`endif

// [inc/nsc_timer_if.sv]
// Load and expiry signals between the sequencer and its delay timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface nsc_timer_if;
  logic load; // Pulse that starts a new delay.
  nsc_pkg::nsc_count_t count; // Delay length in cycles.
  logic done; // High once the delay has run out.
  modport seq (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// [logic/nsc_host.sv]
// Host-side controller for a byte-wide nonvolatile SRAM port.
// Assumes a clockless device on the pins and a user on the same clock.
`timescale 1ns/1ps
`include "nsc_regs.svh"
module nsc_host #(
  parameter int POWERUP_CYCLES = `NSC_PU_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [14:0] req_addr_i,
  input wire logic [7:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  output logic mem_sel_n_o,
  output logic mem_strobe_n_o,
  output logic mem_gate_n_o,
  output logic [14:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  output logic [7:0] mem_data_o,
  output logic mem_data_oe_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.
  ////////////////////////////////////////////////////////////////////////
  nsc_timer_if tif (); // Link to the delay timer.
  nsc_pkg::nsc_state_t state; // Current sequencer state.
  nsc_pkg::nsc_state_t next_state; // Next sequencer state.
  nsc_pkg::nsc_count_t cyc; // Cycles since select fell.
  nsc_pkg::nsc_count_t next_cyc; // Next value of cyc.
  logic sel_n; // Select pin level.
  logic next_sel_n; // Next select level.
  logic strobe_n; // Strobe pin level.
  logic next_strobe_n; // Next strobe level.
  logic gate_n; // Gate pin level.
  logic next_gate_n; // Next gate level.
  logic [14:0] addr; // Address held on the pins.
  logic [14:0] next_addr; // Next address.
  logic [7:0] wdata; // Write data held on the pins.
  logic [7:0] next_wdata; // Next write data.
  logic drive; // Host drives the data lines.
  logic next_drive; // Next drive enable.
  logic [7:0] rdata; // Captured read byte.
  logic [7:0] next_rdata; // Next read byte.
  logic rvalid; // Read response pulse.
  logic next_rvalid; // Next response pulse.
  logic [7:0] din_meta; // First synchronizer stage.
  logic [7:0] din_sync; // Second synchronizer stage.
  logic load; // Timer load pulse.
  nsc_pkg::nsc_count_t load_val; // Timer load value.

  ////////////////////////////////////////////////////////////////////////
  // Delay timer.
  ////////////////////////////////////////////////////////////////////////
  assign tif.load = load;
  assign tif.count = load_val;

  // The timer paces every pin phase of the sequence except the one-cycle NSC_TURN step.
  nsc_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .t(tif.tmr)
  );

  ////////////////////////////////////////////////////////////////////////
  // Data pin synchronizer.
  ////////////////////////////////////////////////////////////////////////
  // The device drives the data pins with no clock, so they pass two stages.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end else if (en_i) begin
      din_meta <= mem_data_i;
      din_sync <= din_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state.
  ////////////////////////////////////////////////////////////////////////
  // One access at a time: select low, phase wait, select high, pre-charge.
  always_comb begin
    next_state = state;
    next_cyc = cyc;
    next_sel_n = sel_n;
    next_strobe_n = strobe_n;
    next_gate_n = gate_n;
    next_addr = addr;
    next_wdata = wdata;
    next_drive = drive;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    load = 1'b0;
    load_val = '0;
    if (cyc != '1) begin
      next_cyc = cyc + 23'h000001;
    end
    case (state)
      nsc_pkg::NSC_POWERUP: begin
        // Hold every control high until the supply wait ends.
        if (cyc == '0) begin
          // First enabled cycle after reset starts the supply wait.
          load = 1'b1;
          load_val = nsc_nc(POWERUP_CYCLES);
        end else if (tif.done) begin
          next_state = nsc_pkg::NSC_IDLE;
        end
      end
      nsc_pkg::NSC_IDLE: begin
        // Take a request; address and select change on the same clock edge.
        if (req_valid_i) begin
          next_addr = req_addr_i;
          next_wdata = req_wdata_i;
          next_sel_n = 1'b0;
          next_cyc = 23'h000001;
          load = 1'b1;
          if (req_write_i) begin
            // Strobe falls with select: a select-controlled write.
            next_strobe_n = 1'b0;
            next_state = nsc_pkg::NSC_WR_SEL;
            load_val = nsc_nc(`NSC_TA_CYC);
          end else begin
            next_gate_n = 1'b0;
            next_state = nsc_pkg::NSC_READ;
            load_val = nsc_nc(`NSC_RD_CYC);
          end
        end
      end
      nsc_pkg::NSC_READ: begin
        // Sample after access time plus synchronizer delay.
        if (tif.done && cyc >= nsc_nc(`NSC_SEL_CYC)) begin
          next_rdata = din_sync;
          next_rvalid = 1'b1;
          next_sel_n = 1'b1;
          next_gate_n = 1'b1;
          next_state = nsc_pkg::NSC_TURN;
          load = 1'b1;
          load_val = nsc_nc(`NSC_TA_CYC);
        end
      end
      nsc_pkg::NSC_WR_SEL: begin
        // Device drivers are off once the release time has passed.
        if (tif.done) begin
          next_drive = 1'b1;
          next_state = nsc_pkg::NSC_WR_STRB;
          load = 1'b1;
          load_val = nsc_nc(`NSC_STRB_CYC);
        end
      end
      nsc_pkg::NSC_WR_STRB: begin
        // Raise strobe and select together after data setup and 70 ns.
        if (tif.done && cyc >= nsc_nc(`NSC_WR_CYC)) begin
          next_strobe_n = 1'b1;
          next_sel_n = 1'b1;
          next_state = nsc_pkg::NSC_TURN;
          load = 1'b1;
          load_val = nsc_nc(`NSC_STROBE_TO_DRIVE_MIN_NS / 4);
        end
      end
      nsc_pkg::NSC_TURN: begin
        // Release host drivers before the device could drive again.
        next_drive = 1'b0;
        next_state = nsc_pkg::NSC_PRECHG;
        if (!load) begin
          load = 1'b1;
          load_val = nsc_nc(`NSC_PC_CYC - 1);
        end
      end
      nsc_pkg::NSC_PRECHG: begin
        // Select stays high for pre-charge and the full cycle time.
        if (tif.done && cyc >= nsc_nc(`NSC_CYC_CYC)) begin
          next_state = nsc_pkg::NSC_IDLE;
        end
      end
      default: begin
        next_state = nsc_pkg::NSC_IDLE;
        next_sel_n = 1'b1;
        next_strobe_n = 1'b1;
        next_gate_n = 1'b1;
        next_drive = 1'b0;
      end
    endcase
  end

  // Sizes an integer count to the counter width.
  function automatic nsc_pkg::nsc_count_t nsc_nc(input int n);
    nsc_nc = n[22:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sequencer registers.
  ////////////////////////////////////////////////////////////////////////
  // Registers only; the enable freezes the whole sequence.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= nsc_pkg::NSC_POWERUP;
      cyc <= '0;
      sel_n <= 1'b1;
      strobe_n <= 1'b1;
      gate_n <= 1'b1;
      addr <= 15'h0000;
      wdata <= 8'h00;
      drive <= 1'b0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else if (en_i) begin
      state <= next_state;
      cyc <= next_cyc;
      sel_n <= next_sel_n;
      strobe_n <= next_strobe_n;
      gate_n <= next_gate_n;
      addr <= next_addr;
      wdata <= next_wdata;
      drive <= next_drive;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.
  ////////////////////////////////////////////////////////////////////////
  assign req_ready_o = (state == nsc_pkg::NSC_IDLE);
  assign rsp_valid_o = rvalid;
  assign rsp_rdata_o = rdata;
  assign mem_sel_n_o = sel_n;
  assign mem_strobe_n_o = strobe_n;
  assign mem_gate_n_o = gate_n;
  assign mem_addr_o = addr;
  assign mem_data_o = wdata;
  assign mem_data_oe_o = drive;
endmodule // nsc_host

// [logic/nsc_timer.sv]
// Down-counting delay timer for the host port sequencer.
// Assumes load is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
module nsc_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  nsc_timer_if.tmr t
);
  nsc_pkg::nsc_count_t remain; // Cycles left in the current delay.
  nsc_pkg::nsc_count_t next_remain; // Next value of the counter.

  // Next counter value: reload, count down, or hold at zero.
  always_comb begin
    next_remain = remain;
    if (t.load) begin
      next_remain = t.count;
    end else if (remain != '0) begin
      next_remain = remain - 23'h000001;
    end
  end

  // Register the counter; the enable freezes it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= '0;
    end else if (en_i) begin
      remain <= next_remain;
    end
  end

  // The delay is over when the counter is empty; the load is kept out of
  // this term because the sequencer computes its load from done.
  assign t.done = (remain == '0);
endmodule // nsc_timer

// [tb/nsc_host_assertions.sv]
// Pin timing checks for the host port controller.
// Assumes it is bound to nsc_host with the same power-up count.
`timescale 1ns/1ps
module nsc_host_assertions #(
  parameter int POWERUP_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rsp_valid_o,
  input wire logic mem_sel_n_o,
  input wire logic mem_strobe_n_o,
  input wire logic mem_gate_n_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic mem_data_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  int lo_cnt; // Cycles select has been low.
  int hi_cnt; // Cycles select has been high.
  int cyc_cnt; // Cycles since the last select fall.
  int up_cnt; // Cycles since reset release, saturating.
  // Span counters; they saturate so idle time cannot wrap them.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_cnt <= 0;
      hi_cnt <= 1000;
      cyc_cnt <= 1000;
      up_cnt <= 0;
    end else begin
      lo_cnt <= mem_sel_n_o ? 0 : (lo_cnt < 1000 ? lo_cnt + 1 : lo_cnt);
      hi_cnt <= !mem_sel_n_o ? 0 : (hi_cnt < 1000 ? hi_cnt + 1 : hi_cnt);
      cyc_cnt <= $fell(mem_sel_n_o) ? 1 : (cyc_cnt < 1000 ? cyc_cnt + 1 : 1000);
      up_cnt <= (up_cnt < POWERUP_CYCLES) ? up_cnt + 1 : up_cnt;
    end
  end
  // A read opens with select and gate together, a write with the strobe.
  sequence rd_open_s;
    $fell(mem_sel_n_o) && !mem_gate_n_o;
  endsequence
  sequence wr_open_s;
    $fell(mem_sel_n_o) && !mem_strobe_n_o;
  endsequence
  sel_active_a: assert property ($rose(mem_sel_n_o) |-> lo_cnt >= 18)
    else $error("select low time too short");
  strobe_sel_a: assert property ($rose(mem_strobe_n_o) |-> lo_cnt >= 18)
    else $error("strobe rose too soon after select fall");
  precharge_a: assert property ($fell(mem_sel_n_o) |-> hi_cnt >= 15)
    else $error("pre-charge too short");
  cycle_time_a: assert property ($fell(mem_sel_n_o) |-> cyc_cnt >= 33)
    else $error("access spacing too short");
  powerup_wait_a: assert property ($fell(mem_sel_n_o) |-> up_cnt >= POWERUP_CYCLES)
    else $error("access during power-up wait");
  read_answer_a: assert property (rd_open_s |-> ##[19:23] rsp_valid_o)
    else $error("read answer out of window");
  addr_hold_a: assert property (wr_open_s |=> $stable(mem_addr_o) [*4])
    else $error("address moved after select fall");
  strobe_in_sel_a: assert property (!mem_strobe_n_o |-> !mem_sel_n_o)
    else $error("strobe low outside select");
  gate_quiet_a: assert property (!mem_strobe_n_o |-> mem_gate_n_o)
    else $error("gate low during write");
  oe_late_a: assert property ($rose(mem_data_oe_o) |-> !$past(mem_strobe_n_o, 4))
    else $error("host drove data before device release");
  oe_release_a: assert property ($rose(mem_strobe_n_o) |=> !mem_data_oe_o)
    else $error("host held data after strobe rise");
endmodule // nsc_host_assertions

// [tb/nsc_mem_model.sv]
// Behavioural model of the byte-wide nonvolatile memory on the host pins.
// Assumes active-low select, strobe and gate; it has no clock.
`timescale 1ns/1ps
module nsc_mem_model (
  input wire logic sel_n_i,
  input wire logic strobe_n_i,
  input wire logic gate_n_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] host_d_i,
  input wire logic host_oe_i,
  output logic [7:0] dq_o,
  output logic conflict_o
);
  logic [7:0] mem [0:32767]; // Cells keep data with no clock or power.
  logic [14:0] addr_q; // Address taken at select fall.
  logic wr_on = 0; // A write is open.
  logic drv = 0; // Device drives the data lines.
  logic [7:0] noise = 8'hA5; // Floating lines wander.
  realtime t_sel; // Time of the last select fall.
  bit prompt = 0; // Answer early instead of at the limit.
  initial conflict_o = 0;
  always #3 noise = noise + 8'h3B;
  // Released lines show a moving pattern, never the last value.
  assign dq_o = host_oe_i ? host_d_i : (drv ? mem[addr_q] : noise);
  always @(negedge sel_n_i) begin
    addr_q = addr_i;
    t_sel = $realtime;
    wr_on = !strobe_n_i;
  end
  always @(negedge strobe_n_i) begin
    if (!sel_n_i) wr_on = 1;
    drv <= #(prompt ? 1 : 15) 1'b0;
  end
  // First rising edge of select or strobe closes the write.
  always @(posedge sel_n_i or posedge strobe_n_i) begin
    if (wr_on) mem[addr_q] = dq_o;
    wr_on = 0;
  end
  always @(posedge gate_n_i or posedge sel_n_i)
    drv <= #(prompt ? 1 : 15) 1'b0;
  // Gate only opens the drivers once both access times have run.
  always @(negedge gate_n_i or negedge sel_n_i or posedge strobe_n_i) begin
    #(prompt ? 10 : 12);
    while ($realtime - t_sel < (prompt ? 1 : 70)) #1;
    if (!sel_n_i && !gate_n_i && strobe_n_i && !wr_on) drv = 1;
  end
  always @(host_oe_i or drv) if (host_oe_i && drv) conflict_o = 1;
endmodule // nsc_mem_model

// [tb/test_nsc_host.sv]
// Self-checking bench for the host port controller and memory model.
// Assumes a 4 ns clock and a shortened power-up wait.
`timescale 1ns/1ps
module test_nsc_host;
  localparam int PU = 20; // Shortened power-up wait in cycles.
  logic clk_i = 0, rst_n_i = 0, en_i = 1, req_valid_i = 0, req_write_i = 0;
  logic [14:0] req_addr_i = 15'h0000, mem_addr_o;
  logic [7:0] req_wdata_i = 8'h00, mem_data_i, mem_data_o, rsp_rdata_o;
  logic req_ready_o, rsp_valid_o, mem_sel_n_o, mem_strobe_n_o;
  logic mem_gate_n_o, mem_data_oe_o, conflict;
  int n_fail = 0, n_tests = 0;
  logic [14:0] ta [4] = '{15'h0000, 15'h7FFF, 15'h1234, 15'h4AC3};
  logic [7:0] td [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
  always #2 clk_i = ~clk_i;
  nsc_host #(.POWERUP_CYCLES(PU)) nsc_host_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .en_i(en_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .mem_sel_n_o(mem_sel_n_o), .mem_strobe_n_o(mem_strobe_n_o),
    .mem_gate_n_o(mem_gate_n_o), .mem_addr_o(mem_addr_o),
    .mem_data_i(mem_data_i), .mem_data_o(mem_data_o),
    .mem_data_oe_o(mem_data_oe_o));
  nsc_mem_model nsc_mem_model_i (.sel_n_i(mem_sel_n_o),
    .strobe_n_i(mem_strobe_n_o), .gate_n_i(mem_gate_n_o),
    .addr_i(mem_addr_o), .host_d_i(mem_data_o), .host_oe_i(mem_data_oe_o),
    .dq_o(mem_data_i), .conflict_o(conflict));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One request, held until taken; a read waits for its answer.
  task automatic xfer(logic wr, logic [14:0] a, logic [7:0] d,
      output logic [7:0] q);
    int n = 0;
    @(negedge clk_i);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, wr, a, d};
    // Ready is looked at mid-cycle, where it is settled.
    while (req_ready_o !== 1'b1 && n < 400) begin
      n++;
      @(negedge clk_i);
    end
    chk("request taken", 1, n < 400);
    @(negedge clk_i);
    req_valid_i = 0;
    n = 0;
    while (!wr && rsp_valid_o !== 1'b1 && n < 60) begin
      n++;
      @(negedge clk_i);
    end
    chk("read answered", 1, n < 60);
    q = rsp_rdata_o;
  endtask
  task automatic t_powerup();
    @(negedge clk_i);
    {req_valid_i, req_write_i} = 2'b11;
    repeat (PU - 4) begin
      @(negedge clk_i);
      chk("ready in power-up", 0, req_ready_o);
      chk("select in power-up", 1, mem_sel_n_o);
    end
    req_valid_i = 0;
  endtask
  task automatic t_rw();
    logic [7:0] q;
    foreach (ta[i]) xfer(1, ta[i], td[i], q);
    foreach (ta[i]) begin
      xfer(0, ta[i], 8'h00, q);
      chk("read back", td[i], q);
    end
    xfer(1, 15'h1234, 8'h3C, q);
    xfer(0, 15'h1234, 8'h00, q);
    chk("overwrite", 8'h3C, q);
  endtask
  task automatic t_prompt();
    logic [7:0] q;
    nsc_mem_model_i.prompt = 1;
    xfer(0, 15'h7FFF, 8'h00, q);
    chk("quick read", 8'h5A, q);
    nsc_mem_model_i.prompt = 0;
  endtask
  task automatic t_freeze();
    logic [7:0] q;
    // Freeze while idle, so a held request would otherwise be taken.
    @(negedge clk_i);
    while (req_ready_o !== 1'b1) @(negedge clk_i);
    {en_i, req_valid_i, req_write_i} = 3'b010;
    repeat (10) begin
      @(negedge clk_i);
      chk("select while frozen", 1, mem_sel_n_o);
    end
    {en_i, req_valid_i} = 2'b10;
    xfer(0, 15'h4AC3, 8'h00, q);
    chk("read after freeze", 8'h00, q);
  endtask
  // Data must survive a mid-run reset and a new power-up wait.
  task automatic t_reset();
    logic [7:0] q;
    @(negedge clk_i);
    rst_n_i = 0;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1;
    t_powerup();
    xfer(0, 15'h0000, 8'h00, q);
    chk("kept over reset", 8'hA5, q);
  endtask
  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1;
    t_powerup();
    t_rw();
    t_prompt();
    t_freeze();
    t_reset();
    chk("bus contention", 0, conflict);
    complete_run();
  end
  initial begin
    #40000;
    n_fail++;
    complete_run();
  end
endmodule // test_nsc_host
bind nsc_host nsc_host_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES))
  nsc_host_assertions_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .rsp_valid_o(rsp_valid_o), .mem_sel_n_o(mem_sel_n_o),
  .mem_strobe_n_o(mem_strobe_n_o), .mem_gate_n_o(mem_gate_n_o),
  .mem_addr_o(mem_addr_o), .mem_data_oe_o(mem_data_oe_o));
